//--- rtl/otp_params.svh
// Purpose: Constants for the nonvolatile program/verify port
// Assumes: clk_i is the oscillator clock, 100 MHz
// Notes:   Offsets are relative to the area base selected by the mode code
`ifndef OTP_PARAMS_SVH
`define OTP_PARAMS_SVH

// ***************************************
// Mode codes on port 0
// ***************************************
`define MODE_PROGRAM_STROBE_N_CODE   8'h68
`define MODE_VER_CODE    8'h28
`define MODE_PROGRAM_STROBE_N_CFG    8'h69
`define MODE_VER_CFG     8'h29
`define MODE_PROGRAM_STROBE_N_LOCK   8'h6b
`define MODE_VER_LOCK    8'h2b
`define MODE_PROGRAM_STROBE_N_ENC    8'h6c

// ***************************************
// Offsets and pulse counts
// ***************************************
`define CODE_LAST        16'h3fff
`define CFG_ZERO_OFS     16'h0080
`define CFG_ONE_OFS      16'h0081
`define CFG_LAST         16'h0083
`define LOCK_ONE_OFS     16'h0001
`define LOCK_THREE_OFS   16'h0003
`define LOCK_VER_OFS     16'h0000
`define ENC_LAST         16'h007f
`define SIG_ZERO_OFS     16'h0030
`define SIG_ONE_OFS      16'h0031
`define SIG_TWO_OFS      16'h0060
`define PULSES_SHORT     5'h05
`define PULSES_LONG      5'h19

// ***************************************
// Configuration fields and defaults
// ***************************************
`define CFG_RESET        8'hff
`define UNIMPL_READ      8'hff
`define C0_WAIT_LOW      5
`define C0_LATCH         4
`define C0_RD_HI         3
`define C0_RD_LO         2
`define C0_PAGE          1
`define C0_SRC           0
`define C1_FRAME         4
`define C1_WAIT_ONE      3
`define C1_MIRROR_OFF    0
`define LOCK_LSB         1

// ***************************************
// Memory map and timing
// ***************************************
`define REGION_LOW       8'h00
`define REGION_ONE       8'h01
`define REGION_FE        8'hfe
`define REGION_FF        8'hff
`define MIRROR_BASE      16'he000
`define ONCHIP_LAST      16'h3fff
`define UPPER_CODE_BASE  14'h2000
`define RD_LIMIT         24'h7fffff
`define CLK_PERIOD_NS    10
`define VERIFY_MAX_T     48
`define VERIFY_MAX_CYC   ((`VERIFY_MAX_T * `CLK_PERIOD_NS) / `CLK_PERIOD_NS)

`endif

//--- rtl/otp_pkg.sv
// Purpose: Types for the nonvolatile program/verify port
// Assumes: Constants come from otp_params.svh
// Notes:   Variant codes follow the part-number digit
package otp_pkg;

  typedef enum logic [1:0] {VAR_OTP, VAR_ROM, VAR_NONE} variant_t;

  typedef enum logic [3:0] {
    OP_NONE, OP_PROGRAM_STROBE_N_CODE, OP_VER_CODE, OP_PROGRAM_STROBE_N_CFG, OP_VER_CFG,
    OP_PROGRAM_STROBE_N_LOCK, OP_VER_LOCK, OP_PROGRAM_STROBE_N_ENC, OP_VER_SIG
  } op_t;

  typedef enum logic [1:0] {PH_IDLE, PH_LOW, PH_DONE} phase_t;

  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  addr_hi;
    logic [7:0]  addr_lo;
    logic [7:0]  data;
    logic        strobe_n;
    logic        enable;
  } program_strobe_n_pins_t;

  typedef struct packed {
    logic        wait_state;
    logic        latch_stretch;
    logic        read_strobe;
    logic        fetch_strobe;
    logic        read_as_a16;
    logic        read_as_port;
    logic        page_mode;
    logic        source_mode;
    logic        push_four;
    logic        onchip_hit;
    logic [13:0] onchip_index;
  } bus_cfg_t;

endpackage

//--- rtl/otp_program_verify_port.sv
// Purpose: Program/verify access to code, config, lock, encryption, signature
// Assumes: Pins synchronous to clk_i; clk_i is the oscillator clock
// Notes:   Runtime decode of the configuration bytes drives bus_o
`timescale 1ns/1ps
`include "otp_params.svh"

module otp_program_verify_port
#(
  parameter otp_pkg::variant_t VARIANT = otp_pkg::VAR_OTP,
  parameter logic [7:0]        SIG_ZERO = 8'h11,   // Arbitrary value
  parameter logic [7:0]        SIG_ONE  = 8'h22,   // Arbitrary value
  parameter logic [7:0]        SIG_TWO  = 8'h33    // Arbitrary value
)
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire otp_pkg::program_strobe_n_pins_t pins_i,
  input  wire logic [23:0]       cpu_addr_i,
  output logic [7:0]             data_o,
  output logic                   data_oe_o,
  output logic [7:0]             config_byte_zero_o,
  output logic [7:0]             config_byte_one_o,
  output logic [2:0]             lock_o,
  output otp_pkg::bus_cfg_t      bus_o
);
  import otp_pkg::*;

  // ***************************************
  // State
  // ***************************************
  typedef struct packed {
    logic [7:0] cfg0;
    logic [7:0] cfg1;
    logic [2:0] lock;
    phase_t     phase;
    logic [4:0] pulses;
    op_t        last_op;
    logic [15:0] last_ofs;
    logic       strobe_q;
    logic [7:0] data;
    logic       data_oe;
    bus_cfg_t   bus;
  } state_t;

  state_t     state_reg;
  state_t     state_next;
  logic [7:0] code_mem [0:16383];
  logic [7:0] enc_mem  [0:127];

  // Mode code to operation
  function automatic op_t decode_op(input logic [7:0] m, input logic [15:0] ofs);
    op_t o;
    o = OP_NONE;
    unique case (m)
      `MODE_PROGRAM_STROBE_N_CODE: o = OP_PROGRAM_STROBE_N_CODE;
      `MODE_VER_CODE:  o = OP_VER_CODE;
      `MODE_PROGRAM_STROBE_N_CFG:  o = OP_PROGRAM_STROBE_N_CFG;
      `MODE_VER_CFG:   o = (ofs[15:8] == 8'h00 && ofs[7] == 1'b0) ? OP_VER_SIG : OP_VER_CFG;
      `MODE_PROGRAM_STROBE_N_LOCK: o = OP_PROGRAM_STROBE_N_LOCK;
      `MODE_VER_LOCK:  o = OP_VER_LOCK;
      `MODE_PROGRAM_STROBE_N_ENC:  o = OP_PROGRAM_STROBE_N_ENC;
      default:         o = OP_NONE;
    endcase
    return o;
  endfunction

  // Whether the variant may run this operation
  function automatic logic op_allowed(input op_t o);
    logic ok;
    ok = 1'b0;
    unique case (o)
      OP_PROGRAM_STROBE_N_CODE, OP_PROGRAM_STROBE_N_CFG, OP_PROGRAM_STROBE_N_LOCK, OP_PROGRAM_STROBE_N_ENC: ok = (VARIANT == VAR_OTP);
      OP_VER_CODE, OP_VER_LOCK, OP_VER_SIG: ok = (VARIANT != VAR_NONE);
      OP_VER_CFG:  ok = 1'b1;
      default:     ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic is_program(input op_t o);
    return o inside {OP_PROGRAM_STROBE_N_CODE, OP_PROGRAM_STROBE_N_CFG, OP_PROGRAM_STROBE_N_LOCK, OP_PROGRAM_STROBE_N_ENC};
  endfunction

  logic [15:0] ofs;
  op_t         op;
  logic        allowed;
  logic        rise;
  logic [4:0]  need;
  logic        commit;

  assign ofs     = {pins_i.addr_hi, pins_i.addr_lo};
  assign op      = pins_i.enable ? decode_op(pins_i.mode, ofs) : OP_NONE;
  assign allowed = op_allowed(op);
  assign rise    = pins_i.strobe_n & ~state_reg.strobe_q;
  assign need    = (op == OP_PROGRAM_STROBE_N_LOCK || op == OP_PROGRAM_STROBE_N_ENC) ? `PULSES_LONG
                                                            : `PULSES_SHORT;
  assign commit  = is_program(op) && allowed && state_reg.phase == PH_LOW && rise
                   && state_reg.pulses == need - 5'h01;

  // ***************************************
  // Next state
  // ***************************************
  always_comb
  begin
    logic [7:0] rd;
    logic       rd_ok;
    logic [7:0] region;
    logic [15:0] low;
    state_next          = state_reg;
    rd                  = 8'h00;
    rd_ok               = 1'b0;
    region              = cpu_addr_i[23:16];
    low                 = cpu_addr_i[15:0];
    state_next.strobe_q = pins_i.strobe_n;
    state_next.last_op  = op;
    state_next.last_ofs = ofs;

    // Pulse counting restarts when the target changes
    if (op != state_reg.last_op || ofs != state_reg.last_ofs || !is_program(op))
    begin
      state_next.phase  = PH_IDLE;
      state_next.pulses = 5'h00;
    end
    else
    begin
      unique case (state_reg.phase)
        PH_IDLE: if (!pins_i.strobe_n) state_next.phase = PH_LOW;
        PH_LOW:
        begin
          if (rise)
          begin
            state_next.pulses = state_reg.pulses + 5'h01;
            state_next.phase  = commit ? PH_DONE : PH_IDLE;
          end
        end
        PH_DONE: state_next.phase = PH_DONE;
      endcase
    end

    if (commit && op == OP_PROGRAM_STROBE_N_CFG && ofs == `CFG_ZERO_OFS)
      state_next.cfg0 = pins_i.data;
    if (commit && op == OP_PROGRAM_STROBE_N_CFG && ofs == `CFG_ONE_OFS)
      state_next.cfg1 = pins_i.data;
    if (commit && op == OP_PROGRAM_STROBE_N_LOCK && ofs >= `LOCK_ONE_OFS && ofs <= `LOCK_THREE_OFS)
      state_next.lock[ofs[1:0] - 2'h1] = 1'b1;

    // Verify read mux, only with the strobe held high
    unique case (op)
      OP_VER_CODE:
      begin
        rd_ok = ofs <= `CODE_LAST;
        rd    = code_mem[ofs[13:0]];
      end
      OP_VER_CFG:
      begin
        rd_ok = ofs >= `CFG_ZERO_OFS && ofs <= `CFG_LAST;
        rd    = (ofs == `CFG_ZERO_OFS) ? state_reg.cfg0 :
                (ofs == `CFG_ONE_OFS)  ? state_reg.cfg1 : `UNIMPL_READ;
      end
      OP_VER_LOCK:
      begin
        rd_ok = ofs == `LOCK_VER_OFS;
        rd    = {4'h0, state_reg.lock, 1'b0};
      end
      OP_VER_SIG:
      begin
        rd_ok = ofs == `SIG_ZERO_OFS || ofs == `SIG_ONE_OFS || ofs == `SIG_TWO_OFS;
        rd    = (ofs == `SIG_ZERO_OFS) ? SIG_ZERO :
                (ofs == `SIG_ONE_OFS)  ? SIG_ONE : SIG_TWO;
      end
      default: rd_ok = 1'b0;
    endcase
    state_next.data_oe = rd_ok && allowed && pins_i.strobe_n;
    state_next.data    = state_next.data_oe ? rd : 8'h00;

    // Runtime decode of the configuration bytes
    state_next.bus.wait_state =
      ((region == `REGION_LOW || region == `REGION_FE || region == `REGION_FF)
        && !state_reg.cfg0[`C0_WAIT_LOW])
      || (region == `REGION_ONE && !state_reg.cfg1[`C1_WAIT_ONE]);
    state_next.bus.latch_stretch = !state_reg.cfg0[`C0_LATCH];
    unique case ({state_reg.cfg0[`C0_RD_HI], state_reg.cfg0[`C0_RD_LO]})
      2'b11:
      begin
        state_next.bus.read_strobe  = cpu_addr_i <= `RD_LIMIT;
        state_next.bus.fetch_strobe = cpu_addr_i >  `RD_LIMIT;
        state_next.bus.read_as_a16  = 1'b0;
        state_next.bus.read_as_port = 1'b0;
      end
      2'b01:
      begin
        state_next.bus.read_strobe  = 1'b0;
        state_next.bus.fetch_strobe = 1'b1;
        state_next.bus.read_as_a16  = 1'b1;
        state_next.bus.read_as_port = 1'b0;
      end
      2'b10:
      begin
        state_next.bus.read_strobe  = 1'b0;
        state_next.bus.fetch_strobe = 1'b1;
        state_next.bus.read_as_a16  = 1'b0;
        state_next.bus.read_as_port = 1'b1;
      end
      default:
      begin
        state_next.bus.read_strobe  = 1'b0;
        state_next.bus.fetch_strobe = 1'b0;
        state_next.bus.read_as_a16  = 1'b0;
        state_next.bus.read_as_port = 1'b0;
      end
    endcase
    state_next.bus.page_mode   = !state_reg.cfg0[`C0_PAGE];
    state_next.bus.source_mode = state_reg.cfg0[`C0_SRC];
    state_next.bus.push_four   = state_reg.cfg1[`C1_FRAME];
    if (region == `REGION_FF && low <= `ONCHIP_LAST)
    begin
      state_next.bus.onchip_hit   = 1'b1;
      state_next.bus.onchip_index = low[13:0];
    end
    else if (region == `REGION_LOW && low >= `MIRROR_BASE
             && !state_reg.cfg1[`C1_MIRROR_OFF])
    begin
      state_next.bus.onchip_hit   = 1'b1;
      state_next.bus.onchip_index = `UPPER_CODE_BASE | {1'b0, low[12:0]};
    end
    else
    begin
      state_next.bus.onchip_hit   = 1'b0;
      state_next.bus.onchip_index = 14'h0000;
    end
  end

  // ***************************************
  // Registers and arrays
  // ***************************************
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_reg          <= '0;
      state_reg.cfg0     <= `CFG_RESET;
      state_reg.cfg1     <= `CFG_RESET;
      state_reg.strobe_q <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk_i)
  begin
    if (commit && op == OP_PROGRAM_STROBE_N_CODE && ofs <= `CODE_LAST)
      code_mem[ofs[13:0]] <= pins_i.data;
    if (commit && op == OP_PROGRAM_STROBE_N_ENC && ofs <= `ENC_LAST)
      enc_mem[ofs[6:0]] <= pins_i.data;
  end

  assign data_o             = state_reg.data;
  assign data_oe_o          = state_reg.data_oe;
  assign config_byte_zero_o = state_reg.cfg0;
  assign config_byte_one_o  = state_reg.cfg1;
  assign lock_o             = state_reg.lock;
  assign bus_o              = state_reg.bus;

  // ***************************************
  // Assertions
  // ***************************************
  property p_cfg_written;
    @(posedge clk_i) disable iff (rst_i)
    commit && op == OP_PROGRAM_STROBE_N_CFG && ofs == `CFG_ZERO_OFS
      |=> config_byte_zero_o == $past(pins_i.data);
  endproperty
  a_cfg_written: assert property (p_cfg_written) else $error("cfg zero not written");

  property p_no_program_strobe_n_rom;
    @(posedge clk_i) disable iff (rst_i)
    VARIANT != VAR_OTP |-> $stable({config_byte_zero_o, config_byte_one_o, lock_o});
  endproperty
  a_no_program_strobe_n_rom: assert property (p_no_program_strobe_n_rom) else $error("stored bits changed");

  property p_verify_latency;
    @(posedge clk_i) disable iff (rst_i)
    (op == OP_VER_CFG && ofs == `CFG_ONE_OFS && pins_i.strobe_n)[*2] |-> ##[0:47] data_oe_o;
  endproperty
  a_verify_latency: assert property (p_verify_latency) else $error("verify data late");

  property p_lock_view;
    @(posedge clk_i) disable iff (rst_i)
    data_oe_o && $past(op) == OP_VER_LOCK |-> data_o[3:1] == $past(lock_o) && data_o[0] == 1'b0;
  endproperty
  a_lock_view: assert property (p_lock_view) else $error("lock verify data wrong");

  property p_no_enc_read;
    @(posedge clk_i) disable iff (rst_i)
    $past(op) inside {OP_PROGRAM_STROBE_N_ENC, OP_PROGRAM_STROBE_N_CODE, OP_PROGRAM_STROBE_N_LOCK} |-> !data_oe_o;
  endproperty
  a_no_enc_read: assert property (p_no_enc_read) else $error("port driven in program");

  property p_wait_one;
    @(posedge clk_i) disable iff (rst_i)
    cpu_addr_i[23:16] == `REGION_ONE && !config_byte_one_o[`C1_WAIT_ONE] |=> bus_o.wait_state;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("region one wait missing");

  property p_fetch_split;
    @(posedge clk_i) disable iff (rst_i)
    config_byte_zero_o[3:2] == 2'b11 && $stable(config_byte_zero_o)
      |=> bus_o.read_strobe != bus_o.fetch_strobe;
  endproperty
  a_fetch_split: assert property (p_fetch_split) else $error("strobe split wrong");

  property p_mirror;
    @(posedge clk_i) disable iff (rst_i)
    cpu_addr_i[23:13] == 11'h007 && config_byte_one_o[`C1_MIRROR_OFF] |=> !bus_o.onchip_hit;
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror shown while off");
endmodule

//--- verif/otp_programmer.sv
// Purpose: Programmer model driving the program/verify pins
// Assumes: Pins change at the falling edge of clk_i
// Notes:   Strobe gap is GAP_CYC cycles, shortened to keep runs brief
`timescale 1ns/1ps

module otp_programmer
#(
  parameter int GAP_CYC = 48
)
(
  input  wire logic                clk_i,
  input  wire logic [7:0]          data_i,
  input  wire logic                data_oe_i,
  output otp_pkg::program_strobe_n_pins_t      pins_o
);
  import otp_pkg::*;

  initial
  begin
    pins_o          = '0;
    pins_o.strobe_n = 1'b1;
    pins_o.enable   = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // ***************************************
  // Program: setup, strobe pulses, hold
  // ***************************************
  task automatic program_strobe_n(input logic [7:0] mode, input logic [15:0] ofs,
                      input logic [7:0] data, input int pulses);
    @(negedge clk_i);
    pins_o.mode                      = mode;
    {pins_o.addr_hi, pins_o.addr_lo} = ofs;
    pins_o.data                      = data;
    wait_cyc(48);
    repeat (pulses)
    begin
      pins_o.strobe_n = 1'b0;
      wait_cyc(4);
      pins_o.strobe_n = 1'b1;
      wait_cyc(GAP_CYC);
    end
    pins_o.data = ~data;
    pins_o.mode = 8'h00;
  endtask

  // ***************************************
  // Verify: strobe high unless strobe_low, data pins inverted
  // ***************************************
  task automatic verify(input logic [7:0] mode, input logic [15:0] ofs,
                        input logic strobe_low, output logic [7:0] d, output logic oe);
    @(negedge clk_i);
    pins_o.mode                      = mode;
    {pins_o.addr_hi, pins_o.addr_lo} = ofs;
    pins_o.strobe_n                  = ~strobe_low;
    pins_o.data                      = ~pins_o.data;
    wait_cyc(48);
    d               = data_i;
    oe              = data_oe_i;
    pins_o.strobe_n = 1'b1;
    pins_o.mode     = 8'h00;
  endtask
endmodule

//--- verif/testbench.sv
// Purpose: Self-checking bench for the program/verify port
// Assumes: Default variant; signature parameters left at defaults
// Notes:   Reserved configuration bits are always written as ones
`timescale 1ns/1ps
`include "otp_params.svh"

module testbench;
  import otp_pkg::*;

  logic        clk_i;
  logic        rst_i;
  program_strobe_n_pins_t  pins;
  logic [23:0] cpu_addr;
  logic [7:0]  data_o;
  logic        data_oe;
  logic [7:0]  cfg0;
  logic [7:0]  cfg1;
  logic [2:0]  lock;
  bus_cfg_t    bus;
  int          mismatches;
  int          tests_run;
  int          cycles;
  logic [7:0]  d;
  logic        oe;
  logic [7:0]  rom_cfg1;
  logic        rom_oe;
  logic [15:0] sig_ofs [3] = '{16'h0030, 16'h0031, 16'h0060};
  logic [7:0]  sig_val [3] = '{8'h11, 8'h22, 8'h33};

  otp_program_verify_port #(.SIG_ZERO(8'h11), .SIG_ONE(8'h22), .SIG_TWO(8'h33))
    u_otp_program_verify_port (
    .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins), .cpu_addr_i(cpu_addr),
    .data_o(data_o), .data_oe_o(data_oe), .config_byte_zero_o(cfg0),
    .config_byte_one_o(cfg1), .lock_o(lock), .bus_o(bus));

  // Read-only variant on the same pins: must never store
  otp_program_verify_port #(.VARIANT(VAR_ROM)) u_otp_program_verify_port_rom (
    .clk_i(clk_i), .rst_i(rst_i), .pins_i(pins), .cpu_addr_i(cpu_addr),
    .data_o(), .data_oe_o(rom_oe), .config_byte_zero_o(),
    .config_byte_one_o(rom_cfg1), .lock_o(), .bus_o());

  otp_programmer u_otp_programmer (
    .clk_i(clk_i), .data_i(data_o), .data_oe_i(data_oe), .pins_o(pins));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      summarize();
    end
  end

  // ***************************************
  // Shared tasks
  // ***************************************
  task automatic summarize();
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic vfy(input logic [7:0] mode, input logic [15:0] ofs, input logic [7:0] exp);
    u_otp_programmer.verify(mode, ofs, 1'b0, d, oe);
    check("verify_oe", 24'h1, {23'h0, oe});
    check("verify_data", {16'h0, exp}, {16'h0, d});
  endtask

  task automatic dec(input logic [23:0] addr);
    @(negedge clk_i);
    cpu_addr = addr;
    repeat (2) @(negedge clk_i);
  endtask

  // ***************************************
  // Main sequence
  // ***************************************
  initial
  begin
    rst_i      = 1'b1;
    cpu_addr   = 24'h0;
    mismatches = 0;
    tests_run  = 0;
    cycles     = 0;
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    check("cfg0_reset", 24'hff, {16'h0, cfg0});
    check("cfg1_reset", 24'hff, {16'h0, cfg1});
    check("lock_reset", 24'h0, {21'h0, lock});
    dec(24'h00e000);
    check("mirror_off", 24'h0, {9'h0, bus.onchip_hit, bus.onchip_index});
    check("wait_off", 24'h0, {23'h0, bus.wait_state});
    check("reset_latch_page", 24'h0, {22'h0, bus.latch_stretch, bus.page_mode});
    check("reset_src_frame", 24'h3, {22'h0, bus.source_mode, bus.push_four});
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_CFG, 16'h0081, 8'he6, 4);
    check("cfg1_short", 24'hff, {16'h0, cfg1});
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_CFG, 16'h0081, 8'he6, 5);
    check("cfg1_program_strobe_n", 24'he6, {16'h0, cfg1});
    check("rom_cfg1", 24'hff, {16'h0, rom_cfg1});
    vfy(`MODE_VER_CFG, 16'h0081, 8'he6);
    check("rom_ver_oe", 24'h1, {23'h0, rom_oe});
    vfy(`MODE_VER_CFG, 16'h0082, 8'hff);
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_CODE, 16'h3fff, 8'h5a, 5);
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_CODE, 16'h0000, 8'ha5, 5);
    vfy(`MODE_VER_CODE, 16'h3fff, 8'h5a);
    vfy(`MODE_VER_CODE, 16'h0000, 8'ha5);
    for (int i = 1; i <= 3; i++)
    begin
      u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_LOCK, 16'(i), 8'h00, 25);
      check("lock_bits", 24'((1 << i) - 1), {21'h0, lock});
      vfy(`MODE_VER_LOCK, 16'h0000, 8'(((1 << i) - 1) << 1));
    end
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_ENC, 16'h007f, 8'h3c, 25);
    check("enc_oe", 24'h0, {23'h0, data_oe});
    check("enc_cfg1", 24'he6, {16'h0, cfg1});
    for (int i = 0; i < 3; i++)
      vfy(`MODE_VER_CFG, sig_ofs[i], sig_val[i]);
    u_otp_programmer.verify(`MODE_VER_CODE, 16'h3fff, 1'b1, d, oe);
    check("strobe_low_oe", 24'h0, {23'h0, oe});
    u_otp_programmer.verify(`MODE_VER_CFG, 16'h0084, 1'b0, d, oe);
    check("bad_ofs_oe", 24'h0, {23'h0, oe});
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_CFG, 16'h0080, 8'hc5, 5);
    dec(24'h010000);
    check("a16", 24'h3, {22'h0, bus.read_as_a16, bus.fetch_strobe});
    check("wait_one", 24'h1, {23'h0, bus.wait_state});
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_CFG, 16'h0080, 8'hc9, 5);
    dec(24'h020000);
    check("rd_port", 24'h3, {22'h0, bus.read_as_port, bus.fetch_strobe});
    check("no_wait", 24'h0, {23'h0, bus.wait_state});
    u_otp_programmer.program_strobe_n(`MODE_PROGRAM_STROBE_N_CFG, 16'h0080, 8'hcd, 5);
    vfy(`MODE_VER_CFG, 16'h0080, 8'hcd);
    dec(24'h00e123);
    check("wait_low", 24'h1, {23'h0, bus.wait_state});
    check("latch", 24'h1, {23'h0, bus.latch_stretch});
    check("page", 24'h1, {23'h0, bus.page_mode});
    check("source", 24'h1, {23'h0, bus.source_mode});
    check("push_four", 24'h0, {23'h0, bus.push_four});
    check("mirror", 24'h6123, {9'h0, bus.onchip_hit, bus.onchip_index});
    check("rd_low", 24'h2, {22'h0, bus.read_strobe, bus.fetch_strobe});
    dec(24'h7fffff);
    check("rd_top", 24'h2, {22'h0, bus.read_strobe, bus.fetch_strobe});
    dec(24'h800000);
    check("fetch_hi", 24'h1, {22'h0, bus.read_strobe, bus.fetch_strobe});
    dec(24'hff0080);
    check("code_only", 24'h4080, {9'h0, bus.onchip_hit, bus.onchip_index});
    summarize();
  end
endmodule
